// >>> hdlc_event_pkg.sv
// constants, field layout and carrier types of the hdlc event status bank
// assumes a 32-bit avalon-mm slave port with byte addresses and one system clock
package hdlc_event_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_MASK   = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_CLEAR  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = IDX_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = IDX_MASK << 2;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR  = IDX_CLEAR << 2;

  // bit positions in status, mask and clear registers
  localparam int BIT_CODE_CHANGE  = 7;
  localparam int BIT_PKT_END      = 6;
  localparam int BIT_PKT_START    = 5;
  localparam int BIT_RX_HALF_FULL = 4;
  localparam int BIT_RX_NOT_EMPTY = 3;
  localparam int BIT_TX_HALF_EMPT = 2;
  localparam int BIT_TX_NOT_FULL  = 1;
  localparam int BIT_TX_MSG_END   = 0;

  // bits that are latched events; the rest follow the fifo conditions
  localparam logic [REG_W-1:0] LATCHED_BITS = 8'hE1;

  localparam logic [REG_W-1:0]  STATUS_RST = 8'h00;
  localparam logic [REG_W-1:0]  MASK_RST   = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST  = 32'h0000_0000;

  // fifo geometry, levels count bytes held
  localparam int LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] FIFO_DEPTH = 7'h40;
  localparam logic [LEVEL_W-1:0] FIFO_HALF  = 7'h20;

  // one-cycle event strobes and levels from the hdlc engine
  typedef struct packed {
    logic code_detect;
    logic pkt_valid_end;
    logic pkt_crc_err;
    logic pkt_overrun;
    logic pkt_abort;
    logic pkt_start;
    logic tx_msg_end;
  } hdlc_events_t;

  typedef struct packed {
    logic rx_fifo_half_full;
    logic rx_fifo_not_empty;
    logic tx_fifo_half_empty;
    logic tx_fifo_not_full;
  } fifo_flags_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_DONE
  } bus_state_t;

endpackage

// >>> hdlc_fifo_flags.sv
// live fifo condition flags derived from the receive and transmit fill levels
// assumes both levels come from logic on the same clock, counted in bytes
`timescale 1ns/1ns
module hdlc_fifo_flags (
  input  wire logic [hdlc_event_pkg::LEVEL_W-1:0] rx_level_i,
  input  wire logic [hdlc_event_pkg::LEVEL_W-1:0] tx_level_i,
  output hdlc_event_pkg::fifo_flags_t             flags_o
);

  always_comb begin
    flags_o                    = '0;
    flags_o.rx_fifo_half_full  = rx_level_i > hdlc_event_pkg::FIFO_HALF;
    flags_o.rx_fifo_not_empty  = rx_level_i != '0;
    flags_o.tx_fifo_half_empty = tx_level_i < hdlc_event_pkg::FIFO_HALF;
    flags_o.tx_fifo_not_full   = tx_level_i < hdlc_event_pkg::FIFO_DEPTH;
  end

endmodule // hdlc_fifo_flags

// >>> hdlc_event_status_flags.sv
// hdlc event status bank: status, interrupt mask and clear registers on avalon-mm
// assumes engine strobes and fifo levels are synchronous to mclk_i
`timescale 1ns/1ns

// Summary of operation
// - The status byte sits at index 01h with code change in bit 7 and message end in bit 0.
// - Bit 7 sets whenever the code detector goes from no code to code or back.
// - Bit 6 sets on a valid packet end and on a packet fault from crc, overrun or abort.
// - Bit 5 sets when the receiver sees the opening byte of a new packet.
// - Bit 3 shows that the receive fifo holds at least one byte.
// - Bit 2 shows that the transmit fifo has dropped below half full.
// - Bit 1 shows that the transmit fifo has room for one more byte.
// - Bit 0 sets when the transmitter has sent the last byte of a message.
// - Bits 7, 6, 5 and 0 are latched and clear when software reads the status.
// - A status bit drives the active-low interrupt only when its mask bit is 1.
// - The interrupt returns high once the causing latched bit is read or cleared and nothing else unmasked pends.
module hdlc_event_status_flags (
  input  wire logic                                mclk_i,
  input  wire logic                                sys_rst_i,
  input  wire logic [hdlc_event_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                                avs_read_i,
  input  wire logic                                avs_write_i,
  input  wire logic [hdlc_event_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [3:0]                          avs_byteenable_i,
  output logic      [hdlc_event_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic                                     avs_waitrequest_o,
  input  hdlc_event_pkg::hdlc_events_t             events_i,
  input  wire logic [hdlc_event_pkg::LEVEL_W-1:0]  rx_fifo_level_i,
  input  wire logic [hdlc_event_pkg::LEVEL_W-1:0]  tx_fifo_level_i,
  output logic                                     irq_n_o
);

  // bus handshake
  hdlc_event_pkg::bus_state_t              bus_state_r;
  hdlc_event_pkg::bus_state_t              bus_state_nxt;
  logic [hdlc_event_pkg::DATA_W-1:0]       rdata_r;
  logic [hdlc_event_pkg::DATA_W-1:0]       rdata_nxt;

  // event state
  logic                                    code_prev_r;
  logic                                    code_prev_nxt;
  logic [hdlc_event_pkg::REG_W-1:0]        latched_r;
  logic [hdlc_event_pkg::REG_W-1:0]        latched_nxt;
  logic [hdlc_event_pkg::REG_W-1:0]        mask_r;
  logic [hdlc_event_pkg::REG_W-1:0]        mask_nxt;
  logic                                    irq_n_r;
  logic                                    irq_n_nxt;

  // combinational helpers
  hdlc_event_pkg::fifo_flags_t             live_flags;
  logic [hdlc_event_pkg::REG_W-1:0]        set_vec;
  logic [hdlc_event_pkg::REG_W-1:0]        live_vec;
  logic [hdlc_event_pkg::REG_W-1:0]        status_view;
  logic [hdlc_event_pkg::REG_W-1:0]        read_clr;
  logic [hdlc_event_pkg::REG_W-1:0]        write_clr;
  logic                                    req;
  logic                                    done;
  logic                                    hit_status;
  logic                                    hit_mask;
  logic                                    hit_clear;
  logic                                    rd_capture;
  logic                                    rd_status_done;
  logic                                    wr_mask_done;
  logic                                    wr_clear_done;
  logic                                    pkt_fault;
  logic [hdlc_event_pkg::REG_W-1:0]        pend_vec;
  logic                                    irq_any;

  hdlc_fifo_flags u_fifo_flags (
    .rx_level_i (rx_fifo_level_i),
    .tx_level_i (tx_fifo_level_i),
    .flags_o    (live_flags)
  );

  // address decode
  always_comb begin
    req        = avs_read_i | avs_write_i;
    done       = req & (bus_state_r == hdlc_event_pkg::BUS_DONE);
    hit_status = avs_address_i == hdlc_event_pkg::ADDR_STATUS;
    hit_mask   = avs_address_i == hdlc_event_pkg::ADDR_MASK;
    hit_clear  = avs_address_i == hdlc_event_pkg::ADDR_CLEAR;
  end

  // qualified strobes; a write acts only with the low byte lane enabled
  always_comb begin
    rd_capture     = avs_read_i & (bus_state_r == hdlc_event_pkg::BUS_IDLE);
    rd_status_done = done & avs_read_i & hit_status;
    wr_mask_done   = done & avs_write_i & hit_mask & avs_byteenable_i[0];
    wr_clear_done  = done & avs_write_i & hit_clear & avs_byteenable_i[0];
  end

  // a packet ends cleanly or in one of three faults, both set the same bit
  always_comb begin
    pkt_fault = events_i.pkt_crc_err
              | events_i.pkt_overrun
              | events_i.pkt_abort;
  end

  // event strobes mapped onto status bit positions
  always_comb begin
    set_vec = '0;
    set_vec[hdlc_event_pkg::BIT_CODE_CHANGE] = events_i.code_detect ^ code_prev_r;
    set_vec[hdlc_event_pkg::BIT_PKT_END]     = events_i.pkt_valid_end | pkt_fault;
    set_vec[hdlc_event_pkg::BIT_PKT_START]   = events_i.pkt_start;
    set_vec[hdlc_event_pkg::BIT_TX_MSG_END]  = events_i.tx_msg_end;
  end

  // live fifo conditions mapped onto status bit positions
  always_comb begin
    live_vec = '0;
    live_vec[hdlc_event_pkg::BIT_RX_HALF_FULL] = live_flags.rx_fifo_half_full;
    live_vec[hdlc_event_pkg::BIT_RX_NOT_EMPTY] = live_flags.rx_fifo_not_empty;
    live_vec[hdlc_event_pkg::BIT_TX_HALF_EMPT] = live_flags.tx_fifo_half_empty;
    live_vec[hdlc_event_pkg::BIT_TX_NOT_FULL]  = live_flags.tx_fifo_not_full;
  end

  // per status bit: what software sees, the next latched state and the
  // interrupt contribution; a set in the same cycle as a clear wins
  for (genvar b = 0; b < hdlc_event_pkg::REG_W; b++) begin : g_bit
    if (hdlc_event_pkg::LATCHED_BITS[b]) begin : g_latched
      assign status_view[b] = latched_r[b];
      assign latched_nxt[b] = (latched_r[b] & ~(read_clr[b] | write_clr[b]))
                            | set_vec[b];
      assign pend_vec[b]    = latched_nxt[b] & mask_nxt[b];
    end else begin : g_live
      assign status_view[b] = live_vec[b];
      assign latched_nxt[b] = 1'b0;
      assign pend_vec[b]    = live_vec[b] & mask_nxt[b];
    end
  end

  // bus state: one wait cycle, then the answer
  always_comb begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      hdlc_event_pkg::BUS_IDLE: begin
        if (req) begin
          bus_state_nxt = hdlc_event_pkg::BUS_DONE;
        end
      end
      hdlc_event_pkg::BUS_DONE: begin
        bus_state_nxt = hdlc_event_pkg::BUS_IDLE;
      end
    endcase
  end

  // read data captured in the wait cycle, unmapped reads return zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_capture) begin
      rdata_nxt = '0;
      if (hit_status) begin
        rdata_nxt[hdlc_event_pkg::REG_W-1:0] = status_view;
      end else if (hit_mask) begin
        rdata_nxt[hdlc_event_pkg::REG_W-1:0] = mask_r;
      end
    end
  end

  always_comb begin
    avs_waitrequest_o = req & (bus_state_r != hdlc_event_pkg::BUS_DONE);
    avs_readdata_o    = rdata_r;
  end

  // a completed status read clears only the latched bits it returned, so an
  // event that lands after the capture is kept for the next read
  always_comb begin
    read_clr = '0;
    if (rd_status_done) begin
      read_clr = rdata_r[hdlc_event_pkg::REG_W-1:0] & hdlc_event_pkg::LATCHED_BITS;
    end
  end

  // the clear register drops latched bits written as one; live bits ignore it
  always_comb begin
    write_clr = '0;
    if (wr_clear_done) begin
      write_clr = avs_writedata_i[hdlc_event_pkg::REG_W-1:0] & hdlc_event_pkg::LATCHED_BITS;
    end
  end

  // code detector level, kept one cycle to spot its changes
  always_comb begin
    code_prev_nxt = events_i.code_detect;
  end

  // interrupt mask register
  always_comb begin
    mask_nxt = mask_r;
    if (wr_mask_done) begin
      mask_nxt = avs_writedata_i[hdlc_event_pkg::REG_W-1:0];
    end
  end

  // active-low interrupt, low while any unmasked bit stands
  always_comb begin
    irq_any   = |pend_vec;
    irq_n_nxt = ~irq_any;
    irq_n_o   = irq_n_r;
  end

  // bus handshake state and read data
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bus_state_r <= hdlc_event_pkg::BUS_IDLE;
      rdata_r     <= hdlc_event_pkg::RDATA_RST;
    end else begin
      bus_state_r <= bus_state_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // event state
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      code_prev_r <= 1'b0;
      latched_r   <= hdlc_event_pkg::STATUS_RST;
    end else begin
      code_prev_r <= code_prev_nxt;
      latched_r   <= latched_nxt;
    end
  end

  // mask register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mask_r <= hdlc_event_pkg::MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // interrupt output register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= irq_n_nxt;
    end
  end

endmodule // hdlc_event_status_flags

// >>> hdlc_event_chk.sv
// checker: port-level assertions for the hdlc event status bank
// assumes one clock; mask is tracked from completed bus writes
`timescale 1ns/1ns
module hdlc_event_chk (
  input wire logic                    mclk_i,
  input wire logic                    sys_rst_i,
  input wire logic [7:0]              avs_address_i,
  input wire logic                    avs_read_i,
  input wire logic                    avs_write_i,
  input wire logic [31:0]             avs_writedata_i,
  input wire logic [3:0]              avs_byteenable_i,
  input wire logic [31:0]             avs_readdata_o,
  input wire logic                    avs_waitrequest_o,
  input hdlc_event_pkg::hdlc_events_t events_i,
  input wire logic [6:0]              rx_fifo_level_i,
  input wire logic [6:0]              tx_fifo_level_i,
  input wire logic                    irq_n_o
);
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  always_comb begin
    mask_nxt = mask_r;
    if (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h08 && avs_byteenable_i[0])
      mask_nxt = avs_writedata_i[7:0];
  end
  always_ff @(posedge mclk_i) mask_r <= sys_rst_i ? 8'h00 : mask_nxt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  chk_one_wait: assert property (
    $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bad wait");
  chk_upper_zero: assert property (
    avs_readdata_o[31:8] == 24'h0) else $error("read data upper bits set");
  chk_code_irq: assert property (
    $changed(events_i.code_detect) && mask_r[7] |=> !irq_n_o) else $error("no code irq");
  chk_end_irq: assert property (
    (events_i.pkt_valid_end || events_i.pkt_crc_err || events_i.pkt_overrun
     || events_i.pkt_abort) && mask_r[6] |=> !irq_n_o) else $error("no packet end irq");
  chk_start_irq: assert property (
    events_i.pkt_start && mask_r[5] |=> !irq_n_o) else $error("no packet start irq");
  chk_msg_irq: assert property (
    events_i.tx_msg_end && mask_r[0] |=> !irq_n_o) else $error("no message end irq");
  chk_masked_quiet: assert property (
    (mask_r == 8'h00)[*2] |-> irq_n_o) else $error("irq with all masked");
  chk_rx_live: assert property (
    (rx_fifo_level_i != 7'h00 && mask_r[3])[*3] |-> !irq_n_o) else $error("no rx irq");
  chk_tx_live: assert property (
    (tx_fifo_level_i < 7'h40 && mask_r[1])[*3] |-> !irq_n_o) else $error("no tx irq");
  cover property (events_i.pkt_start ##1 !irq_n_o);
  cover property ($rose(avs_write_i) && avs_address_i == 8'h20);
  cover property ($changed(events_i.code_detect));
endmodule // hdlc_event_chk

bind hdlc_event_status_flags hdlc_event_chk chk (.mclk_i, .sys_rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .events_i, .rx_fifo_level_i, .tx_fifo_level_i, .irq_n_o);

// >>> test_hdlc_event_status_flags.sv
// testbench: bus, event, live flag and interrupt sequences for the event status bank
// assumes the checker is bound to the design and one clock drives all
`timescale 1ns/1ns
module test_hdlc_event_status_flags;
  logic                         mclk_i           = 1'b0;
  logic                         sys_rst_i        = 1'b1;
  logic [7:0]                   avs_address_i    = 8'h00;
  logic                         avs_read_i       = 1'b0;
  logic                         avs_write_i      = 1'b0;
  logic [31:0]                  avs_writedata_i  = 32'h0;
  logic [3:0]                   avs_byteenable_i = 4'hF;
  logic [31:0]                  avs_readdata_o;
  logic                         avs_waitrequest_o;
  hdlc_event_pkg::hdlc_events_t events_i         = '0;
  logic [6:0]                   rx_fifo_level_i  = 7'h00;
  logic [6:0]                   tx_fifo_level_i  = 7'h40;
  logic                         irq_n_o;
  logic [31:0]                  q;
  int                           failures         = 0;
  int                           n_tests          = 0;
  logic [7:0]  ev_t [6]   = '{8'h01, 8'h20, 8'h40, 8'h40, 8'h40, 8'h40};
  // rx level, tx level, expected status
  logic [20:0] live_t [7] = '{{7'h01, 7'h40, 7'h08}, {7'h21, 7'h40, 7'h18},
    {7'h20, 7'h40, 7'h08}, {7'h00, 7'h1F, 7'h06}, {7'h00, 7'h20, 7'h02},
    {7'h00, 7'h3F, 7'h02}, {7'h00, 7'h40, 7'h00}};
  always #25 mclk_i = ~mclk_i;
  hdlc_event_status_flags uut (.mclk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .events_i, .rx_fifo_level_i, .tx_fifo_level_i, .irq_n_o);
  task automatic test_done();
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one access; entered just after a rising edge, the request holds until the
  // rising edge that samples waitrequest low, read data is taken at that edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_read_i      <= !w;
    avs_write_i     <= w;
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge mclk_i);
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    cmp(q, {24'h0, e});
  endtask
  task automatic ci(input logic e);
    @(negedge mclk_i);
    cmp({31'h0, irq_n_o}, {31'h0, e});
    @(posedge mclk_i);
  endtask
  task automatic pulse(input logic [5:0] p);
    events_i <= {events_i.code_detect, p};
    @(posedge mclk_i);
    events_i <= {events_i.code_detect, 6'h00};
    @(posedge mclk_i);
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h10, 8'h00);
    acc(1'b1, 8'h04, 8'hFF);
    rd(8'h04, 8'h00);
    ci(1'b1);
    acc(1'b1, 8'h08, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      ci(1'b0);
      rd(8'h04, ev_t[i]);
      rd(8'h04, 8'h00);
      ci(1'b1);
    end
    for (int i = 0; i < 2; i++) begin
      events_i.code_detect <= !events_i.code_detect;
      repeat (2) @(posedge mclk_i);
      rd(8'h04, 8'h80);
      rd(8'h04, 8'h00);
    end
    avs_byteenable_i <= 4'h0;
    acc(1'b1, 8'h08, 8'h20);
    avs_byteenable_i <= 4'hF;
    rd(8'h08, 8'hFF);
    acc(1'b1, 8'h08, 8'h20);
    pulse(6'h01);
    ci(1'b1);
    pulse(6'h02);
    ci(1'b0);
    rd(8'h04, 8'h21);
    ci(1'b1);
    pulse(6'h02);
    acc(1'b1, 8'h20, 8'h20);
    ci(1'b1);
    rd(8'h04, 8'h00);
    acc(1'b1, 8'h08, 8'h0A);
    for (int i = 0; i < 7; i++) begin
      rx_fifo_level_i <= live_t[i][20:14];
      tx_fifo_level_i <= live_t[i][13:7];
      repeat (2) @(posedge mclk_i);
      rd(8'h04, {1'b0, live_t[i][6:0]});
      rd(8'h04, {1'b0, live_t[i][6:0]});
      ci(!(|(live_t[i][6:0] & 7'h0A)));
    end
    test_done();
  end
endmodule // test_hdlc_event_status_flags
